// ---- pkg/duaf_pkg.sv ----
// duaf_pkg: constants of the dual-channel alternate-function and reset-state register bank
package duaf_pkg;

    // ------------------------------------------------------------
    // register word offsets inside one channel window
    // ------------------------------------------------------------
    localparam logic [2:0] IER_IDX = 3'h0;
    localparam logic [2:0] LCR_IDX = 3'h1;
    localparam logic [2:0] MCR_IDX = 3'h2;
    localparam logic [2:0] FCR_IDX = 3'h3;
    localparam logic [2:0] AFC_IDX = 3'h4;
    localparam logic [2:0] ISR_IDX = 3'h5;
    localparam logic [2:0] LSR_IDX = 3'h6;
    localparam logic [2:0] MSR_IDX = 3'h7;

    // byte address layout: bits 4..2 word index, bit 5 channel, above must be zero
    localparam int IDX_LSB = 2;
    localparam int CHAN_BIT = 5;
    localparam int ADDR_TOP = 31;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int AFC_CONC_BIT = 0;
    localparam int AFC_SEL_LSB = 1;
    localparam int AFC_SEL_MSB = 2;
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_OUT2_BIT = 3;
    localparam int IER_MODEM_BIT = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ISR_RST = 8'h01;
    localparam logic [7:0] LSR_RST = 8'h60;
    localparam logic [3:0] DELTA_RST = 4'h0;

    // multi-function output select codes
    typedef enum logic [1:0] {
        MF_OUT2 = 2'b00,
        MF_BAUD = 2'b01,
        MF_READY = 2'b10,
        MF_RSVD = 2'b11
    } duaf_mfsel_t;

    // bus transaction phase
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } duaf_bus_t;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HRESP_OKAY = 2'b00;

endpackage

// ---- verilog/duaf_regbank.sv ----
// duaf_regbank: shared alternate-function control and reset-state registers of a two-channel uart
//
// Function
// - Alternate-function bits 7..3 are unused, read as zero, reset to zero.
// - Two-bit select picks exactly one source for each multi-function output.
// - 00 user output two, 01 baud clock, 10 ready indication, 11 reserved.
// - Concurrent bit set: one write updates same register in both channels.
// - Concurrent bit writable through either channel, governs both channels.
// - Reads always follow channel select; concurrent bit never affects reads.
// - Reset clears interrupt-enable, line, modem, fifo control and alternate-function registers.
// - Reset sets interrupt status bit 0, clears bits 7..1.
// - Reset sets line status bits 6..5, clears bit 7 and 4..0.
// - Reset clears modem change flags; upper bits keep following modem inputs.
// - Reset drives serial, user-two, rts, dtr high; interrupt, transmit-ready low.
`timescale 1ns/1ps

module duaf_regbank (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // per-channel sources from the serial engines, index 0 is channel a
    input wire logic [1:0] serialData,
    input wire logic [1:0] baudClock,
    input wire logic [1:0] readyIndication,
    input wire logic [1:0] txReadySrc,
    input wire logic [3:0] modemInA,
    input wire logic [3:0] modemInB,
    // channel a pins
    output logic serialOutChanA,
    output logic userOutputTwoChanA,
    output logic requestToSendChanA,
    output logic terminalReadyChanA,
    output logic interruptOutChanA,
    output logic transmitReadyChanA,
    output logic multiFunctionOutChanA,
    // channel b pins
    output logic serialOutChanB,
    output logic userOutputTwoChanB,
    output logic requestToSendChanB,
    output logic terminalReadyChanB,
    output logic interruptOutChanB,
    output logic transmitReadyChanB,
    output logic multiFunctionOutChanB
);
    import duaf_pkg::*;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] interrupt_enable_reg [2];
    logic [7:0] line_control [2];
    logic [7:0] modem_control [2];
    logic [7:0] fifo_control [2];
    logic [7:0] line_status [2];
    logic [3:0] delta [2];
    logic [3:0] modemPrev [2];
    logic [3:0] modemNow [2];
    // one shared copy: either channel window reaches it, and it steers both
    logic [2:0] altFunc;

    duaf_bus_t busState;
    logic [2:0] phaseIdx;
    logic phaseChan;
    logic phaseMapped;

    logic accept;
    logic wrCommit;
    logic rdCommit;
    logic [1:0] wrChanHit;
    logic [7:0] wrByte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // address is mapped when nothing above the channel bit is set and bits 1..0 are zero
    function automatic logic addrMapped(input logic [31:0] a);
        addrMapped = (a[ADDR_TOP:CHAN_BIT + 1] == '0) && (a[IDX_LSB - 1:0] == 2'b00);
    endfunction

    // pending modem-status event on one channel
    function automatic logic modemIrq(input logic [7:0] en, input logic [3:0] d);
        modemIrq = en[IER_MODEM_BIT] && (d != 4'h0);
    endfunction

    // read view of one register of one channel
    function automatic logic [7:0] readReg(input logic c, input logic [2:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IER_IDX: v = interrupt_enable_reg[c];
            LCR_IDX: v = line_control[c];
            MCR_IDX: v = modem_control[c];
            FCR_IDX: v = fifo_control[c];
            AFC_IDX: v = {5'h00, altFunc};
            ISR_IDX: v = {7'h00, ~modemIrq(interrupt_enable_reg[c], delta[c])};
            LSR_IDX: v = line_status[c];
            MSR_IDX: v = {modemNow[c], delta[c]};
            default: v = 8'h00;
        endcase
        readReg = v;
    endfunction

    assign modemNow[0] = modemInA;
    assign modemNow[1] = modemInB;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wrCommit = (busState == BUS_WRITE) && phaseMapped;
    assign rdCommit = (busState == BUS_READ) && phaseMapped;
    assign wrByte = hwdata[7:0];

    // write steering: selected channel, or both while the concurrent bit is set
    always_comb begin
        wrChanHit = 2'b00;
        if (wrCommit) begin
            if (altFunc[AFC_CONC_BIT]) begin
                wrChanHit = 2'b11;
            end else begin
                wrChanHit[phaseChan] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait state
    // ------------------------------------------------------------
    // the read wait state lets a write in the preceding data phase settle
    // before the read mux is sampled, so no forwarding path is needed
    always_ff @(posedge mclk) begin
        if (rst) begin
            busState <= BUS_IDLE;
            phaseIdx <= 3'h0;
            phaseChan <= 1'b0;
            phaseMapped <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            case (busState)
                BUS_READ: begin
                    busState <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    if (accept) begin
                        busState <= hwrite ? BUS_WRITE : BUS_READ;
                        phaseIdx <= haddr[IDX_LSB + 2:IDX_LSB];
                        phaseChan <= haddr[CHAN_BIT];
                        phaseMapped <= addrMapped(haddr);
                        hreadyout <= hwrite;
                    end else begin
                        busState <= BUS_IDLE;
                        hreadyout <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hresp <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
        end
    end

    // read data follows the channel bit of the address only
    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rdCommit) begin
            hrdata <= {24'h00_0000, readReg(phaseChan, phaseIdx)};
        end else if (busState == BUS_READ) begin
            hrdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int c = 0; c < 2; c++) begin
                interrupt_enable_reg[c] <= CTRL_RST;
                line_control[c] <= CTRL_RST;
                modem_control[c] <= CTRL_RST;
                fifo_control[c] <= CTRL_RST;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wrChanHit[c]) begin
                    case (phaseIdx)
                        IER_IDX: interrupt_enable_reg[c] <= wrByte;
                        LCR_IDX: line_control[c] <= wrByte;
                        MCR_IDX: modem_control[c] <= wrByte;
                        FCR_IDX: fifo_control[c] <= wrByte;
                        default: interrupt_enable_reg[c] <= interrupt_enable_reg[c];
                    endcase
                end
            end
        end
    end

    // any channel window writes the shared copy
    always_ff @(posedge mclk) begin
        if (rst) begin
            altFunc <= CTRL_RST[2:0];
        end else if (wrCommit && (phaseIdx == AFC_IDX)) begin
            altFunc <= wrByte[AFC_SEL_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    // line status has no engine behind it here; it holds its idle value
    always_ff @(posedge mclk) begin
        if (rst) begin
            line_status[0] <= LSR_RST;
            line_status[1] <= LSR_RST;
        end else begin
            line_status[0] <= line_status[0];
            line_status[1] <= line_status[1];
        end
    end

    // modem change flags: a change in the same cycle as the clearing read wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int c = 0; c < 2; c++) begin
                delta[c] <= DELTA_RST;
                // track the live inputs so no false change is flagged after reset
                modemPrev[c] <= modemNow[c];
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                modemPrev[c] <= modemNow[c];
                if (rdCommit && (phaseIdx == MSR_IDX) && (phaseChan == c[0])) begin
                    delta[c] <= modemNow[c] ^ modemPrev[c];
                end else begin
                    delta[c] <= delta[c] | (modemNow[c] ^ modemPrev[c]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    // control pins are active low: a cleared modem control bit reads as high
    always_ff @(posedge mclk) begin
        if (rst) begin
            serialOutChanA <= 1'b1;
            serialOutChanB <= 1'b1;
            userOutputTwoChanA <= 1'b1;
            userOutputTwoChanB <= 1'b1;
            requestToSendChanA <= 1'b1;
            requestToSendChanB <= 1'b1;
            terminalReadyChanA <= 1'b1;
            terminalReadyChanB <= 1'b1;
            interruptOutChanA <= 1'b0;
            interruptOutChanB <= 1'b0;
            transmitReadyChanA <= 1'b0;
            transmitReadyChanB <= 1'b0;
        end else begin
            serialOutChanA <= serialData[0];
            serialOutChanB <= serialData[1];
            userOutputTwoChanA <= ~modem_control[0][MCR_OUT2_BIT];
            userOutputTwoChanB <= ~modem_control[1][MCR_OUT2_BIT];
            requestToSendChanA <= ~modem_control[0][MCR_RTS_BIT];
            requestToSendChanB <= ~modem_control[1][MCR_RTS_BIT];
            terminalReadyChanA <= ~modem_control[0][MCR_DTR_BIT];
            terminalReadyChanB <= ~modem_control[1][MCR_DTR_BIT];
            interruptOutChanA <= modemIrq(interrupt_enable_reg[0], delta[0]);
            interruptOutChanB <= modemIrq(interrupt_enable_reg[1], delta[1]);
            transmitReadyChanA <= txReadySrc[0];
            transmitReadyChanB <= txReadySrc[1];
        end
    end

    // multi-function pins: one source at a time, reserved code parks high
    always_ff @(posedge mclk) begin
        if (rst) begin
            multiFunctionOutChanA <= 1'b1;
            multiFunctionOutChanB <= 1'b1;
        end else begin
            case (duaf_mfsel_t'(altFunc[AFC_SEL_MSB:AFC_SEL_LSB]))
                MF_OUT2: begin
                    multiFunctionOutChanA <= ~modem_control[0][MCR_OUT2_BIT];
                    multiFunctionOutChanB <= ~modem_control[1][MCR_OUT2_BIT];
                end
                MF_BAUD: begin
                    multiFunctionOutChanA <= baudClock[0];
                    multiFunctionOutChanB <= baudClock[1];
                end
                MF_READY: begin
                    multiFunctionOutChanA <= readyIndication[0];
                    multiFunctionOutChanB <= readyIndication[1];
                end
                default: begin
                    multiFunctionOutChanA <= 1'b1;
                    multiFunctionOutChanB <= 1'b1;
                end
            endcase
        end
    end

endmodule

// ---- sim/duaf_regbank_asserts.sv ----
// duaf_regbank_asserts: bus and pin checks bound to the register bank
`timescale 1ns/1ps

module duaf_regbank_asserts (
    // clock, reset, bus
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [31:0] hrdata,
    // sources and pins
    input wire logic [1:0] baudClock,
    input wire logic [1:0] readyIndication,
    input wire logic serialOutChanA,
    input wire logic userOutputTwoChanA,
    input wire logic requestToSendChanA,
    input wire logic terminalReadyChanA,
    input wire logic interruptOutChanA,
    input wire logic transmitReadyChanA,
    input wire logic multiFunctionOutChanA,
    input wire logic userOutputTwoChanB,
    input wire logic multiFunctionOutChanB
);
    default clocking cb @(posedge mclk);
    endclocking
    logic wAfc;
    logic rAfc;
    logic [2:0] afcSh;
    logic isAfc;
    assign isAfc = haddr[31:6] == 26'h0 && haddr[4:0] == 5'h10;
    // one shared copy, so writes through either window land here
    always_ff @(posedge mclk) begin
        if (rst) begin
            wAfc <= 1'b0;
            rAfc <= 1'b0;
            afcSh <= 3'h0;
        end else begin
            if (hready)
                wAfc <= hsel && htrans == 2'h2 && hwrite && isAfc;
            if (hsel && hready && htrans == 2'h2 && !hwrite)
                rAfc <= isAfc;
            if (wAfc && hready)
                afcSh <= hwdata[2:0];
        end
    end
    rst_high_a:
        assert property (rst |=> serialOutChanA && userOutputTwoChanA && requestToSendChanA && terminalReadyChanA)
        else $error("pin not high in reset");
    rst_low_a:
        assert property (rst |=> !interruptOutChanA && !transmitReadyChanA)
        else $error("pin not low in reset");
    reset_ctrl_a:
        assert property ($fell(rst) |-> (multiFunctionOutChanA && userOutputTwoChanA) [*2])
        else $error("control not cleared by reset");
    mf_out2_a:
        assert property (disable iff (rst) afcSh[2:1] == 2'b00 |=>
            multiFunctionOutChanA == userOutputTwoChanA && multiFunctionOutChanB == userOutputTwoChanB)
        else $error("mf not user output two");
    mf_baud_a:
        assert property (disable iff (rst) afcSh[2:1] == 2'b01 |=>
            {multiFunctionOutChanB, multiFunctionOutChanA} == $past(baudClock))
        else $error("mf not baud clock");
    mf_ready_a:
        assert property (disable iff (rst) afcSh[2:1] == 2'b10 |=>
            {multiFunctionOutChanB, multiFunctionOutChanA} == $past(readyIndication))
        else $error("mf not ready");
    afc_read_a:
        assert property (disable iff (rst) $rose(hreadyout) && rAfc |-> hrdata[7:0] == {5'h0, afcSh})
        else $error("alternate-function read wrong");
    resp_okay_a:
        assert property (disable iff (rst) hresp == 2'b00)
        else $error("response not okay");
    read_wait_a:
        assert property (disable iff (rst) hsel && hready && htrans == 2'h2 && !hwrite
            |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule

bind duaf_regbank duaf_regbank_asserts chk (.*);

// ---- sim/duaf_engine_model.sv ----
// duaf_engine_model: stand-in for the serial engines and modem lines
`timescale 1ns/1ps

module duaf_engine_model (
    // clock and requested levels
    input wire logic mclk,
    input wire logic [15:0] want,
    // sources toward the bank, bit 0 is channel a
    output logic [1:0] serialData,
    output logic [1:0] baudClock,
    output logic [1:0] readyIndication,
    output logic [1:0] txReadySrc,
    output logic [3:0] modemInA,
    output logic [3:0] modemInB
);
    // engines register their outputs, so a new level lands one edge late
    logic [15:0] held = 16'h0;
    always @(posedge mclk) begin
        held <= want;
    end
    assign {modemInB, modemInA, txReadySrc, readyIndication, baudClock, serialData} = held;
endmodule

// ---- sim/tb.sv ----
// tb: ahb-lite master and pin checks for the register bank
`timescale 1ns/1ps

module tb;
    import duaf_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    // modem b, modem a, tx ready, ready, baud, serial
    logic [15:0] want = 16'h30e4;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [1:0] serialData, baudClock, readyIndication, txReadySrc;
    logic [3:0] modemInA, modemInB;
    // per channel: serial, user two, rts, dtr, int, tx ready, mf; a on top
    logic [13:0] pins;
    logic [7:0] q;
    logic [1:0] mfExp [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    int nMismatch = 0;
    int testsRun = 0;

    always #25 mclk = ~mclk;

    duaf_engine_model eng (.mclk(mclk), .want(want), .serialData(serialData), .baudClock(baudClock),
        .readyIndication(readyIndication), .txReadySrc(txReadySrc), .modemInA(modemInA), .modemInB(modemInB));

    duaf_regbank uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .serialData(serialData), .baudClock(baudClock), .readyIndication(readyIndication),
        .txReadySrc(txReadySrc), .modemInA(modemInA), .modemInB(modemInB),
        .serialOutChanA(pins[13]), .userOutputTwoChanA(pins[12]), .requestToSendChanA(pins[11]),
        .terminalReadyChanA(pins[10]), .interruptOutChanA(pins[9]), .transmitReadyChanA(pins[8]),
        .multiFunctionOutChanA(pins[7]), .serialOutChanB(pins[6]), .userOutputTwoChanB(pins[5]),
        .requestToSendChanB(pins[4]), .terminalReadyChanB(pins[3]), .interruptOutChanB(pins[2]),
        .transmitReadyChanB(pins[1]), .multiFunctionOutChanB(pins[0]));

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // look at hready mid-cycle, where it is settled; the next rising edge is the one that samples it
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            nMismatch++;
            report_and_stop();
        end
        q = hrdata[7:0];
        @(posedge mclk);
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
        haddr <= a;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask

    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h0);
        chk({24'h0, q}, {24'h0, e});
    endtask

    function automatic logic [31:0] ad(input logic ch, input logic [2:0] idx);
        return {26'h0, ch, idx, 2'h0};
    endfunction

    task automatic do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1 chk({18'h0, pins}, {18'h0, 14'h3cf9});
        @(posedge mclk);
    endtask

    initial begin
        do_reset();
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 8; i++)
                rdc(ad(c[0], i[2:0]), i == 7 ? {(c[0] ? 4'h3 : 4'h0), 4'h0} :
                    (i == 5 ? ISR_RST : (i == 6 ? LSR_RST : CTRL_RST)));
        $display("test reset state done");
        xfer(1'b1, ad(1'b0, LCR_IDX), 8'h5a);
        rdc(ad(1'b0, LCR_IDX), 8'h5a);
        rdc(ad(1'b1, LCR_IDX), 8'h00);
        xfer(1'b1, ad(1'b1, AFC_IDX), 8'h01);
        rdc(ad(1'b0, AFC_IDX), 8'h01);
        xfer(1'b1, ad(1'b0, MCR_IDX), 8'h0b);
        rdc(ad(1'b1, MCR_IDX), 8'h0b);
        rdc(ad(1'b1, LCR_IDX), 8'h00);
        chk({18'h0, pins}, {18'h0, 14'h0102});
        xfer(1'b1, ad(1'b0, LSR_IDX), 8'hff);
        rdc(ad(1'b0, LSR_IDX), LSR_RST);
        xfer(1'b1, 32'h40, 8'h77);
        rdc(32'h40, 8'h00);
        $display("test concurrent write done");
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, ad(1'b0, AFC_IDX), {5'h1f, s[1:0], 1'b0});
            rdc(ad(1'b1, AFC_IDX), {5'h0, s[1:0], 1'b0});
            chk({30'h0, pins[7], pins[0]}, {30'h0, mfExp[s]});
        end
        $display("test output select done");
        xfer(1'b1, ad(1'b0, IER_IDX), 8'h08);
        want <= 16'h35e4;
        // engine, change flag and pin each add one edge
        repeat (3) @(posedge mclk);
        rdc(ad(1'b0, ISR_IDX), 8'h00);
        chk({31'h0, pins[9]}, 32'h1);
        rdc(ad(1'b0, MSR_IDX), 8'h55);
        rdc(ad(1'b0, MSR_IDX), 8'h50);
        rdc(ad(1'b0, ISR_IDX), ISR_RST);
        rdc(ad(1'b1, MSR_IDX), 8'h30);
        $display("test modem status done");
        do_reset();
        rdc(ad(1'b0, MSR_IDX), 8'h50);
        rdc(ad(1'b1, AFC_IDX), CTRL_RST);
        rdc(ad(1'b0, MCR_IDX), CTRL_RST);
        rdc(ad(1'b0, IER_IDX), CTRL_RST);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
